/* lfcc_consts.svh */
// Constants for the LCD frame clock and contrast block: offsets, fields,
// reset values and drive times.
// Assumes inclusion by bare name from the package only; the design modules rely on it being compiled first.
`ifndef LFCC_CONSTS_SVH
`define LFCC_CONSTS_SVH

// Bus geometry.
`define LFCC_AW             8
`define LFCC_DW             32
`define LFCC_REG_W          8

// Register byte addresses, one aligned word each.
`define LFCC_OFS_FRAME_RATE 8'h00
`define LFCC_OFS_DRIVE_CON  8'h04
`define LFCC_OFS_PANEL_CTL  8'h08
`define LFCC_OFS_STATUS     8'h0C

// Reset values.
`define LFCC_RST_FRAME_RATE 8'h00
`define LFCC_RST_DRIVE_CON  8'h00
`define LFCC_RST_PANEL_CTL  8'h00

// Writable bits; everything else, reserved bits included, reads as zero.
`define LFCC_MASK_FRAME     8'h77
`define LFCC_MASK_DRIVE     8'hEF
`define LFCC_MASK_PANEL     8'hB1

// Field positions in the frame rate register.
`define LFCC_TAP_HI         6
`define LFCC_TAP_LO         4
`define LFCC_DIV_HI         2
`define LFCC_DIV_LO         0
// Field positions in the drive time and contrast register.
`define LFCC_ONT_HI         7
`define LFCC_ONT_LO         5
`define LFCC_CON_HI         3
`define LFCC_CON_LO         0
// Field positions in the panel control register.
`define LFCC_SRC_BIT        7
`define LFCC_DUTY_HI        5
`define LFCC_DUTY_LO        4
`define LFCC_BLANK_BIT      0

// Prescaler width and tap masks (divide by mask plus one).
`define LFCC_PRE_W          12
`define LFCC_TAP_16         12'h00F
`define LFCC_TAP_64         12'h03F
`define LFCC_TAP_128        12'h07F
`define LFCC_TAP_256        12'h0FF
`define LFCC_TAP_512        12'h1FF
`define LFCC_TAP_1024       12'h3FF
`define LFCC_TAP_2048       12'h7FF
`define LFCC_TAP_4096       12'hFFF

// Frame length in panel clock steps: last step index for K of 8 and 6.
`define LFCC_K8_LAST        3'h7
`define LFCC_K6_LAST        3'h5

// On-time code that always asks for half a panel clock period.
`define LFCC_ONT_HALF       3'h7

// Clock rate and nominal driver on-times in nanoseconds.
`define LFCC_MCLK_MHZ       125
`define LFCC_T_ONT0_NS      250000
`define LFCC_T_ONT1_NS      62500
`define LFCC_T_ONT2_NS      125000
`define LFCC_T_ONT3_NS      375000
`define LFCC_T_ONT4_NS      500000
`define LFCC_T_ONT5_NS      750000
`define LFCC_T_ONT6_NS      1000000
`define LFCC_ONT_CNT_W      17

// AXI responses.
`define LFCC_RESP_OKAY      2'h0
`define LFCC_RESP_SLVERR    2'h2

`endif

/* lfcc_pkg.sv */
// Types shared by the LCD frame clock and contrast block.
// Assumes lfcc_consts.svh sits in the include path.
`include "lfcc_consts.svh"

package lfcc_pkg;

	// Duty selection codes.
	typedef enum logic [1:0] {
		LFCC_DUTY_STATIC  = 2'b00,
		LFCC_DUTY_HALF    = 2'b01,
		LFCC_DUTY_THIRD   = 2'b10,
		LFCC_DUTY_QUARTER = 2'b11
	} lfcc_duty_e;

	// One register write as handed from the bus slave to the register file.
	typedef struct packed {
		logic [`LFCC_AW-1:0]    addr;
		logic [`LFCC_REG_W-1:0] data;
		logic                   laneEn;
	} lfcc_wr_s;

	// Panel side outputs that move together.
	typedef struct packed {
		logic       panelClk;
		logic       frameStart;
		logic       driverOn;
		logic       blanked;
		logic [3:0] contrast;
	} lfcc_panel_s;

endpackage : lfcc_pkg

/* lfcc_sync.sv */
// Two-stage synchroniser for a level arriving from outside the mclk domain.
// Assumes the input may change at any time; only the second stage is read.
`timescale 1ns/1ps

module lfcc_sync
	import lfcc_pkg::*;
(
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic reset_n,
	// Level in and synchronised level out.
	input  wire logic asyncIn,
	output logic      syncOut
);

	logic stage1_ff; // First stage, read only by the second stage.

	// The first stage may go metastable; the second gives it a cycle to settle.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_ff <= 1'b0;
			syncOut   <= 1'b0;
		end else begin
			stage1_ff <= asyncIn;
			syncOut   <= stage1_ff;
		end
	end

endmodule // lfcc_sync

/* lfcc_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the register file decodes the handed-over write and read address.
`timescale 1ns/1ps

module lfcc_axil_slave
	import lfcc_pkg::*;
(
	// Clock and reset.
	input  wire logic                   mclk,
	input  wire logic                   reset_n,
	// Write address and data channels.
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [`LFCC_AW-1:0]    s_axi_awaddr,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	input  wire logic [`LFCC_DW-1:0]    s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	// Write response channel.
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	output logic [1:0]                  s_axi_bresp,
	// Read address and data channels.
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	input  wire logic [`LFCC_AW-1:0]    s_axi_araddr,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [`LFCC_DW-1:0]         s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	// Register file side.
	output logic                        wrEn,
	output lfcc_wr_s                    wrCmd,
	input  wire logic                   wrErr,
	output logic [`LFCC_AW-1:0]         rdAddr,
	input  wire logic [`LFCC_REG_W-1:0] rdData,
	input  wire logic                   rdErr
);

	logic                awHeld_ff; // Write address has been taken.
	logic                wHeld_ff;  // Write data has been taken.
	logic [`LFCC_AW-1:0] awAddr_ff; // Held write address.
	logic [`LFCC_DW-1:0] wData_ff;  // Held write data.
	logic                wLane_ff;  // Held strobe of byte lane zero.

	// Handshakes are decoded by name so the processes stay short.
	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake  = s_axi_wvalid && s_axi_wready;
	wire arTake = s_axi_arvalid && s_axi_arready;

	// Each half is refused once held, until the response has been taken.
	assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_ff && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// The write fires once both halves are held, in whichever order they came.
	assign wrEn         = awHeld_ff && wHeld_ff;
	assign wrCmd.addr   = awAddr_ff;
	assign wrCmd.data   = wData_ff[`LFCC_REG_W-1:0];
	assign wrCmd.laneEn = wLane_ff;
	assign rdAddr       = s_axi_araddr;

	// Write path: hold both halves, then answer at the same edge that performs the write.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld_ff    <= 1'b0;
			wHeld_ff     <= 1'b0;
			awAddr_ff    <= '0;
			wData_ff     <= '0;
			wLane_ff     <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `LFCC_RESP_OKAY;
		end else begin
			if (awTake) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
			end
			if (wTake) begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wLane_ff <= s_axi_wstrb[0];
			end
			if (wrEn) begin
				awHeld_ff    <= 1'b0;
				wHeld_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrErr ? `LFCC_RESP_SLVERR : `LFCC_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read path: data is captured at the address handshake.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `LFCC_RESP_OKAY;
		end else if (arTake) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {{(`LFCC_DW-`LFCC_REG_W){1'b0}}, rdData};
			s_axi_rresp  <= rdErr ? `LFCC_RESP_SLVERR : `LFCC_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // lfcc_axil_slave

/* lfcc_frame_clock.sv */
// LCD frame clock, driver on-time and contrast control, top level.
// Assumes mclk at 125 MHz, an AXI4-Lite master, and an asynchronous
// panel oscillator pin that runs slower than half of mclk.
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module lfcc_frame_clock
	import lfcc_pkg::*;
#(
	// On-time counts in mclk cycles, long enough to be shortened in simulation.
	parameter int unsigned ONT0_CYC = `LFCC_T_ONT0_NS*`LFCC_MCLK_MHZ/1000,
	parameter int unsigned ONT1_CYC = `LFCC_T_ONT1_NS*`LFCC_MCLK_MHZ/1000,
	parameter int unsigned ONT2_CYC = `LFCC_T_ONT2_NS*`LFCC_MCLK_MHZ/1000,
	parameter int unsigned ONT3_CYC = `LFCC_T_ONT3_NS*`LFCC_MCLK_MHZ/1000,
	parameter int unsigned ONT4_CYC = `LFCC_T_ONT4_NS*`LFCC_MCLK_MHZ/1000,
	parameter int unsigned ONT5_CYC = `LFCC_T_ONT5_NS*`LFCC_MCLK_MHZ/1000,
	parameter int unsigned ONT6_CYC = `LFCC_T_ONT6_NS*`LFCC_MCLK_MHZ/1000
) (
	// Clock and reset.
	input  wire logic                mclk,
	input  wire logic                reset_n,
	// AXI4-Lite write address, data and response.
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [`LFCC_AW-1:0] s_axi_awaddr,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [`LFCC_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic [1:0]               s_axi_bresp,
	// AXI4-Lite read address and data.
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [`LFCC_AW-1:0] s_axi_araddr,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic [`LFCC_DW-1:0]      s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	// Asynchronous panel source clock pin.
	input  wire logic                asyncSrcClk,
	// Panel drive outputs toward the analog drivers and regulator.
	output lfcc_panel_s              panel
);

	// Register file state.
	logic [`LFCC_REG_W-1:0] frameRate_ff;   // Frame rate control.
	logic [`LFCC_REG_W-1:0] driveCon_ff;    // Drive time and contrast control.
	logic [`LFCC_REG_W-1:0] panelCtl_ff;    // Source, duty and blanking.
	// Panel timing state.
	logic [`LFCC_PRE_W-1:0] presc_ff;       // Free-running prescaler.
	logic [2:0]             divCnt_ff;      // Divider behind the tap.
	logic [2:0]             stepCnt_ff;     // Panel clock steps in a frame.
	logic [`LFCC_ONT_CNT_W-1:0] elapsed_ff; // mclk cycles since last step.
	logic                   srcPrev_ff;     // Previous synchronised pin level.
	lfcc_panel_s            panel_ff;       // Registered panel outputs.

	// Bus slave hand-over.
	logic                   wrEn;
	lfcc_wr_s               wrCmd;
	logic [`LFCC_AW-1:0]    rdAddr;
	logic                   wrErr;          // Write to an unmapped place.
	logic [`LFCC_REG_W-1:0] rdData;         // Read mux output.
	logic                   rdErr;          // Read of an unmapped place.
	logic                   srcSync;

	// Field views of the registers.
	wire [2:0]  tapSel   = frameRate_ff[`LFCC_TAP_HI:`LFCC_TAP_LO];
	wire [2:0]  divSel   = frameRate_ff[`LFCC_DIV_HI:`LFCC_DIV_LO];
	wire [2:0]  onTime   = driveCon_ff[`LFCC_ONT_HI:`LFCC_ONT_LO];
	wire [3:0]  conLevel = driveCon_ff[`LFCC_CON_HI:`LFCC_CON_LO];
	wire        srcAsync = panelCtl_ff[`LFCC_SRC_BIT];
	wire        blankReq = panelCtl_ff[`LFCC_BLANK_BIT];
	lfcc_duty_e dutySel;
	assign dutySel = lfcc_duty_e'(panelCtl_ff[`LFCC_DUTY_HI:`LFCC_DUTY_LO]);

	// Bus slave; the answer comes one cycle after both halves are held.
	lfcc_axil_slave u_slave (
		.mclk          (mclk),
		.reset_n       (reset_n),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.wrEn          (wrEn),
		.wrCmd         (wrCmd),
		.wrErr         (wrErr),
		.rdAddr        (rdAddr),
		.rdData        (rdData),
		.rdErr         (rdErr)
	);

	// The oscillator pin crosses into mclk before anything looks at it.
	lfcc_sync u_srcSync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.asyncIn (asyncSrcClk),
		.syncOut (srcSync)
	);

	// Address decode, separate for writes and for reads.
	wire wrFrame  = wrEn && wrCmd.laneEn && wrCmd.addr == `LFCC_OFS_FRAME_RATE;
	wire wrDrive  = wrEn && wrCmd.laneEn && wrCmd.addr == `LFCC_OFS_DRIVE_CON;
	wire wrPanel  = wrEn && wrCmd.laneEn && wrCmd.addr == `LFCC_OFS_PANEL_CTL;
	wire wrKnown  = wrCmd.addr == `LFCC_OFS_FRAME_RATE
		|| wrCmd.addr == `LFCC_OFS_DRIVE_CON
		|| wrCmd.addr == `LFCC_OFS_PANEL_CTL
		|| wrCmd.addr == `LFCC_OFS_STATUS;
	assign wrErr  = !wrKnown;
	wire rdFrame  = rdAddr == `LFCC_OFS_FRAME_RATE;
	wire rdDrive  = rdAddr == `LFCC_OFS_DRIVE_CON;
	wire rdPanel  = rdAddr == `LFCC_OFS_PANEL_CTL;
	wire rdStatus = rdAddr == `LFCC_OFS_STATUS;
	assign rdErr  = !(rdFrame || rdDrive || rdPanel || rdStatus);

	// Status shows live timing state: contrast applied, blank, driver on, panel clock.
	wire [`LFCC_REG_W-1:0] statusVal = {panel_ff.contrast, 1'b0,
		panel_ff.blanked, panel_ff.driverOn, panel_ff.panelClk};

	// Read mux; reserved bits are never stored, so they read zero.
	assign rdData =
		rdFrame  ? frameRate_ff :
		rdDrive  ? driveCon_ff  :
		rdPanel  ? panelCtl_ff  :
		rdStatus ? statusVal    : '0;

	// Source clock: every mclk, or each rising edge of the oscillator pin.
	wire srcTick = srcAsync ? (srcSync && !srcPrev_ff) : 1'b1;

	// Tap mask per code; the tap fires when the masked bits are all ones.
	wire [`LFCC_PRE_W-1:0] tapMask =
		tapSel == 3'h0 ? `LFCC_TAP_16   :
		tapSel == 3'h1 ? `LFCC_TAP_64   :
		tapSel == 3'h2 ? `LFCC_TAP_128  :
		tapSel == 3'h3 ? `LFCC_TAP_256  :
		tapSel == 3'h4 ? `LFCC_TAP_512  :
		tapSel == 3'h5 ? `LFCC_TAP_1024 :
		tapSel == 3'h6 ? `LFCC_TAP_2048 : `LFCC_TAP_4096;
	wire tapTick = srcTick && ((presc_ff & tapMask) == tapMask);

	// Divider: one panel step per divide-plus-one taps.
	wire divWrap = divCnt_ff >= divSel;
	wire psTick  = tapTick && divWrap;

	// K of 6 for third duty, 8 otherwise; one frame is K panel steps.
	wire [2:0] stepLast = dutySel == LFCC_DUTY_THIRD
		? `LFCC_K6_LAST : `LFCC_K8_LAST;
	wire frameTick = psTick && stepCnt_ff >= stepLast;

	// Blanking at a frame start takes effect with that strobe.
	wire nxt_blanked = frameTick ? blankReq : panel_ff.blanked;

	// Nominal on-time in cycles from the live code.
	wire [`LFCC_ONT_CNT_W-1:0] onLimit =
		onTime == 3'h0 ? `LFCC_ONT_CNT_W'(ONT0_CYC) :
		onTime == 3'h1 ? `LFCC_ONT_CNT_W'(ONT1_CYC) :
		onTime == 3'h2 ? `LFCC_ONT_CNT_W'(ONT2_CYC) :
		onTime == 3'h3 ? `LFCC_ONT_CNT_W'(ONT3_CYC) :
		onTime == 3'h4 ? `LFCC_ONT_CNT_W'(ONT4_CYC) :
		onTime == 3'h5 ? `LFCC_ONT_CNT_W'(ONT5_CYC) :
		`LFCC_ONT_CNT_W'(ONT6_CYC);

	// Whole half period when asked by code, static duty or blanking.
	wire fullHalf = onTime == `LFCC_ONT_HALF
		|| dutySel == LFCC_DUTY_STATIC || nxt_blanked;

	// The elapsed count restarts each step, which caps on-time at one step.
	wire [`LFCC_ONT_CNT_W-1:0] nxt_elapsed = psTick ? '0 :
		(&elapsed_ff ? elapsed_ff : elapsed_ff + 1'b1);
	wire nxt_driverOn = fullHalf || nxt_elapsed < onLimit;

	// Register file writes; only byte lane zero carries data.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			frameRate_ff <= `LFCC_RST_FRAME_RATE;
			driveCon_ff  <= `LFCC_RST_DRIVE_CON;
			panelCtl_ff  <= `LFCC_RST_PANEL_CTL;
		end else begin
			if (wrFrame) begin
				frameRate_ff <= wrCmd.data & `LFCC_MASK_FRAME;
			end
			if (wrDrive) begin
				driveCon_ff <= wrCmd.data & `LFCC_MASK_DRIVE;
			end
			if (wrPanel) begin
				panelCtl_ff <= wrCmd.data & `LFCC_MASK_PANEL;
			end
		end
	end

	// Prescaler and divider advance on source ticks only.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			presc_ff   <= '0;
			divCnt_ff  <= '0;
			srcPrev_ff <= 1'b0;
		end else begin
			srcPrev_ff <= srcSync;
			if (srcTick) begin
				presc_ff <= presc_ff + 1'b1;
			end
			if (tapTick) begin
				divCnt_ff <= divWrap ? 3'h0 : divCnt_ff + 3'h1;
			end
		end
	end

	// Frame step counter and the driver on-time timer.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stepCnt_ff <= '0;
			elapsed_ff <= '0;
		end else begin
			elapsed_ff <= nxt_elapsed;
			if (psTick) begin
				stepCnt_ff <= frameTick ? 3'h0 : stepCnt_ff + 3'h1;
			end
		end
	end

	// Panel outputs: a frame strobe loads contrast and blanking together.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			panel_ff <= '0;
		end else begin
			panel_ff.frameStart <= frameTick;
			panel_ff.blanked    <= nxt_blanked;
			panel_ff.driverOn   <= nxt_driverOn;
			if (psTick) begin
				panel_ff.panelClk <= !panel_ff.panelClk;
			end
			if (frameTick) begin
				panel_ff.contrast <= conLevel;
			end
		end
	end

	// The regulator maps contrast code c to 2.60 V plus c times 0.05 V.
	assign panel = panel_ff;

endmodule // lfcc_frame_clock

/* lfcc_frame_clock_checker.sv */
// Checker for the LCD frame clock block: bus handshakes and panel timing.
// Assumes a bind to the top module; it sees only that module's ports.
`timescale 1ns/1ps

module lfcc_frame_clock_checker
	import lfcc_pkg::*;
(
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        reset_n,
	// Register bus handshakes.
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	// Panel drive.
	input wire lfcc_panel_s panel
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Both write halves taken at one edge, and a read address taken.
	sequence sWrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence sRdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// The register updates one edge after the take, then bvalid shows.
	a_write_resp_time: assert property (
		sWrTaken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two edges after the request");
	a_read_resp_time: assert property (sRdTaken |=> s_axi_rvalid)
		else $error("read data not one edge after the address");
	a_read_addr_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while data pending");
	a_write_addr_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_read_upper_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read data bits not zero");
	a_frame_pulse_single: assert property (
		panel.frameStart |=> !panel.frameStart)
		else $error("frame start wider than one cycle");
	// A late contrast or blank change would glitch the frame on the glass.
	a_contrast_at_frame: assert property (
		$changed(panel.contrast) |-> panel.frameStart)
		else $error("contrast changed outside a frame start");
	a_blank_at_frame: assert property (
		$changed(panel.blanked) |-> panel.frameStart)
		else $error("blanking changed outside a frame start");
	a_blank_drive_on: assert property (
		panel.blanked && $past(panel.blanked) |-> panel.driverOn)
		else $error("drivers off while blanked");
endmodule // lfcc_frame_clock_checker

bind lfcc_frame_clock lfcc_frame_clock_checker u_checker (.mclk, .reset_n,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rdata, .panel);

/* lfcc_panel_model.sv */
// Panel side model: a free-running panel oscillator and a frame monitor.
// Assumes the panel outputs settle from flops after each mclk edge.
`timescale 1ns/1ps

module lfcc_panel_model
	import lfcc_pkg::*;
(
	// Clock, reset and oscillator enable.
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        oscEn,
	// Panel drive in, oscillator pin out.
	input wire lfcc_panel_s panel,
	output logic            asyncSrcClk,
	// Last whole frame, driver-on cycles in it, last step length.
	output int              framePeriod,
	output int              onCount,
	output int              stepPeriod
);
	int   fCyc, oCyc, sCyc; // Running counts since the last event.
	logic clkPrev;          // Panel clock level at the previous edge.
	// A 40 ns oscillator off phase with mclk; it sits low while disabled.
	initial begin
		asyncSrcClk = 1'b0;
		#3;
		forever #20 asyncSrcClk = oscEn ? ~asyncSrcClk : 1'b0;
	end
	// Figures latch at each event, so the bench always reads whole spans.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			{fCyc, oCyc, sCyc, framePeriod, onCount, stepPeriod} <= '0;
			clkPrev <= 1'b0;
		end else begin
			fCyc <= panel.frameStart ? 0 : fCyc + 1;
			oCyc <= panel.frameStart ? 0 : oCyc + panel.driverOn;
			sCyc <= (panel.panelClk != clkPrev) ? 0 : sCyc + 1;
			clkPrev <= panel.panelClk;
			if (panel.frameStart) begin
				framePeriod <= fCyc + 1;
				onCount <= oCyc + panel.driverOn;
			end
			if (panel.panelClk != clkPrev) stepPeriod <= sCyc + 1;
		end
	end
endmodule // lfcc_panel_model

/* lfcc_frame_clock_tb.sv */
// Bench for the LCD frame clock block: bus tasks and panel measurements.
// Assumes the panel model latches frame and step figures on mclk.
`timescale 1ns/1ps

module lfcc_frame_clock_tb
	import lfcc_pkg::*;
;
	// Short on-times fit a 16-cycle step; the last one overruns it.
	localparam int ONT[7] = '{5, 2, 3, 6, 7, 8, 20};
	localparam int NTAP[8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
	logic        mclk, reset_n, oscEn, asyncSrcClk;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	lfcc_panel_s panel;
	int          framePeriod, onCount, stepPeriod, num_errors, checked;

	lfcc_frame_clock #(.ONT0_CYC(5), .ONT1_CYC(2), .ONT2_CYC(3),
		.ONT3_CYC(6), .ONT4_CYC(7), .ONT5_CYC(8), .ONT6_CYC(20)) dut (
		.mclk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .asyncSrcClk, .panel);
	lfcc_panel_model model (.mclk, .reset_n, .oscEn, .panel, .asyncSrcClk,
		.framePeriod, .onCount, .stepPeriod);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Both halves go out together; each drops at its own accepting edge.
	// The response ready comes a cycle late so bvalid is seen to stand.
	task automatic axWrite(input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] strb = 4'hF);
		logic awDone, wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				awDone = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				wDone = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b1;
		@(posedge mclk);
		chk("bvalid held", s_axi_bvalid, 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axRead(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b1;
		@(posedge mclk);
		chk("rvalid held", s_axi_rvalid, 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// The second frame start closes a frame run wholly on new settings.
	task automatic frame(input int per, input int on);
		repeat (2) do @(posedge mclk); while (panel.frameStart !== 1'b1);
		@(posedge mclk);
		chk("frame length", framePeriod, per);
		if (on >= 0) chk("driver on cycles", onCount, on);
	endtask

	// The first toggle may end a partial step, so wait for three.
	task automatic step(input int exp);
		repeat (3) @(panel.panelClk);
		repeat (2) @(posedge mclk);
		chk("step length", stepPeriod, exp);
	endtask

	// Drivers are on for the whole frame once the limit reaches a step.
	function automatic int onExp(int c);
		if (c == 7 || ONT[c] > 16) return 128;
		return 8 * ONT[c];
	endfunction

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge mclk);
		num_errors++;
		finish_test();
	end

	initial begin
		{reset_n, oscEn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{num_errors, checked} = '0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		// Reset value, then reserved bits under an all-ones write.
		axRead(8'h04);
		chk("drive_time_contrast_control", rd, 32'h00);
		axWrite(8'h00, 8'hFF);
		axRead(8'h00);
		chk("frame_rate_control", rd, 32'h77);
		axWrite(8'h00, 8'h00);
		frame(128, 128);
		// Contrast is held back until the next frame start.
		axWrite(8'h04, 8'h1F);
		chk("early contrast", panel.contrast, 4'h0);
		axRead(8'h04);
		chk("drive_time_contrast_control", rd, 32'h0F);
		// No byte lane zero, or the status place: answered, nothing stored.
		axWrite(8'h04, 8'hA5, 4'hE);
		chk("bresp", rsp, `LFCC_RESP_OKAY);
		axWrite(8'h0C, 8'hFF);
		chk("bresp", rsp, `LFCC_RESP_OKAY);
		axRead(8'h04);
		chk("drive_time_contrast_control", rd, 32'h0F);
		frame(128, -1);
		chk("contrast", panel.contrast, 4'hF);
		axRead(8'h0C);
		chk("status contrast", rd[7:4], 4'hF);
		// An unmapped place answers with an error and zero data.
		axWrite(8'h10, 8'h55);
		chk("bresp", rsp, `LFCC_RESP_SLVERR);
		axRead(8'h10);
		chk("rdata", rd, 32'h0);
		chk("rresp", rsp, `LFCC_RESP_SLVERR);
		for (int t = 0; t < 8; t++) begin
			axWrite(8'h00, {1'b0, 3'(t), 4'h0});
			step(NTAP[t]);
		end
		for (int d = 0; d < 8; d++) begin
			axWrite(8'h00, {5'h00, 3'(d)});
			step(16 * (d + 1));
		end
		// Every duty code; third duty has six steps to a frame.
		axWrite(8'h00, 8'h01);
		for (int m = 0; m < 4; m++) begin
			axWrite(8'h08, {2'h0, 2'(m), 4'h0});
			frame((m == 2 ? 6 : 8) * 32, -1);
		end
		axWrite(8'h00, 8'h00);
		for (int c = 0; c < 8; c++) begin
			axWrite(8'h04, {3'(c), 5'h00});
			frame(128, onExp(c));
		end
		// Blank, let a frame pass, and only then touch the on-time.
		axWrite(8'h08, 8'h31);
		frame(128, 128);
		chk("blanked", panel.blanked, 1'b1);
		axWrite(8'h04, 8'h20);
		frame(128, 128);
		axWrite(8'h08, 8'h30);
		frame(128, 8 * ONT[1]);
		chk("blanked", panel.blanked, 1'b0);
		// The panel oscillator gives one source tick every five cycles.
		oscEn <= 1'b1;
		axWrite(8'h08, 8'hB0);
		step(80);
		finish_test();
	end
endmodule // lfcc_frame_clock_tb
